/* hdl/sdl_pkg.sv */
package sdl_pkg;
	// Word layout: mode, channel, value, most significant bit first
	localparam int WORD_W = 16;
	localparam int MODE_HI = 15;
	localparam int MODE_LO = 13;
	localparam int CHAN_HI = 12;
	localparam int CHAN_LO = 10;
	localparam int CODE_W = 10;
	localparam int CHAN_N = 8;
	localparam int CHAN_W = 3;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;
	localparam logic [2:0] MODE_MAIN = 3'h1;
	localparam int FIFO_DEPTH = 32;
	// Values after reset
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
	localparam logic [2:0] SYNC_RST = 3'h7;
endpackage : sdl_pkg

/* hdl/sdl_loader.sv */
// Summary of operation
// - Data bits are sampled on falling serial clock edges.
// - Words arrive most significant bit first.
// - Bit collection survives clock pauses while frame sync stays low.
// - Load pulse after a word moves that input register to output.
// - One load pulse updates every loaded channel together.
// - Load held low updates the channel on the sixth system clock edge after the sixteenth serial clock.
// - Clock and data are ignored while frame sync is high.
// - Word is mode and channel bits followed by the value.
`timescale 1ns/1ps

// ==========================================================
// Word FIFO
module sdl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;

	// Extra pointer bit tells full from empty
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[rd_ptr_r[AW-1:0]];

	// Storage has no reset; only pointers matter
	always_ff @(posedge i_clk)
	begin
		if (i_in_valid && !full)
			mem[wr_ptr_r[AW-1:0]] <= i_in_data;
	end

	// Write pointer
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			wr_ptr_r <= '0;
		else if (i_in_valid && !full)
			wr_ptr_r <= wr_ptr_r + 1'b1;
	end

	// Read pointer
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rd_ptr_r <= '0;
		else if (i_out_ready && !empty)
			rd_ptr_r <= rd_ptr_r + 1'b1;
	end
endmodule : sdl_fifo

// ==========================================================
// Serial word loader
module sdl_loader
	import sdl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_serial_clock_in,
	input wire logic i_serial_data_in,
	input wire logic i_frame_sync_n,
	input wire logic i_load_outputs_n,
	input wire logic i_clear_outputs_n,
	output logic [CHAN_N*CODE_W-1:0] o_dac_code,
	output logic [WORD_W-1:0] o_ctrl_word,
	output logic o_ctrl_strobe,
	output logic o_link_ready,
	output logic o_word_dropped
);
	logic link_clr;
	logic [CNT_W-1:0] bit_cnt_r;
	logic [WORD_W-2:0] shift_r;
	logic [WORD_W-1:0] hold_r [2];
	logic word_tgl_r;
	logic [2:0] tgl_sync_r;
	logic seen_r;
	logic [2:0] load_sync_r;
	logic [2:0] clr_sync_r;
	logic load_n_r;
	logic clear_n_r;
	logic push;
	logic in_ready;
	logic out_valid;
	logic out_ready;
	logic [WORD_W-1:0] out_word;
	logic [CODE_W-1:0] input_r [CHAN_N];
	logic [CODE_W-1:0] out_code_r [CHAN_N];
	logic [CHAN_W-1:0] chan;

	// ======================================================
	// Link domain, clocked by the host's serial clock
	// Frame sync high or reset clears the bit count without a clock,
	// since the host's clock stands still between frames.
	assign link_clr = i_frame_sync_n | !i_reset_n;

	always_ff @(negedge i_serial_clock_in or posedge link_clr)
	begin
		if (link_clr)
			bit_cnt_r <= CNT_RST;
		else
			bit_cnt_r <= bit_cnt_r + 1'b1;
	end

	// first bit lands at the top
	always_ff @(negedge i_serial_clock_in or negedge i_reset_n)
	begin
		if (!i_reset_n)
			shift_r <= '0;
		else if (!i_frame_sync_n)
			shift_r <= {shift_r[WORD_W-3:0], i_serial_data_in};
	end

	// Two holding words alternate, so each stays still for a whole
	// further word while the system side picks it up.
	always_ff @(negedge i_serial_clock_in or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			hold_r[0] <= WORD_RST;
			hold_r[1] <= WORD_RST;
			word_tgl_r <= 1'b0;
		end
		else if (!i_frame_sync_n && bit_cnt_r == LAST_BIT)
		begin
			hold_r[word_tgl_r] <= {shift_r, i_serial_data_in};
			word_tgl_r <= !word_tgl_r;
		end
	end

	// ======================================================
	// Crossings into the system clock
	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			tgl_sync_r <= 3'h0;
			load_sync_r <= SYNC_RST;
			clr_sync_r <= SYNC_RST;
		end
		else
		begin
			tgl_sync_r <= {tgl_sync_r[1:0], word_tgl_r};
			load_sync_r <= {load_sync_r[1:0], i_load_outputs_n};
			clr_sync_r <= {clr_sync_r[1:0], i_clear_outputs_n};
		end
	end

	// Filtered control levels
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			load_n_r <= 1'b1;
			clear_n_r <= 1'b1;
		end
		else
		begin
			if (load_sync_r[1] == load_sync_r[2])
				load_n_r <= load_sync_r[2];
			if (clr_sync_r[1] == clr_sync_r[2])
				clear_n_r <= clr_sync_r[2];
		end
	end

	// New word seen: the buffer it sits in is the old toggle value
	assign push = (tgl_sync_r[1] == tgl_sync_r[2]) &&
		(tgl_sync_r[2] != seen_r);

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			seen_r <= 1'b0;
		else if (push)
			seen_r <= tgl_sync_r[2];
	end

	// ======================================================
	// Word buffer; the host cannot be stalled, so a full buffer
	// drops the word and raises a sticky flag instead.
	sdl_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(push),
		.o_in_ready(in_ready),
		.i_in_data(hold_r[seen_r]),
		.o_out_valid(out_valid),
		.i_out_ready(out_ready),
		.o_out_data(out_word)
	);

	// Drain stalls while clear is held
	assign out_ready = clear_n_r;
	assign chan = out_word[CHAN_HI:CHAN_LO];

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_link_ready <= 1'b1;
			o_word_dropped <= 1'b0;
		end
		else
		begin
			o_link_ready <= in_ready;
			if (push && !in_ready)
				o_word_dropped <= 1'b1;
		end
	end

	// ======================================================
	// Decode and double-buffered channel registers
	// mode, channel, value
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_ctrl_word <= WORD_RST;
			o_ctrl_strobe <= 1'b0;
		end
		else
		begin
			o_ctrl_strobe <= out_valid && out_ready &&
				out_word[MODE_HI:MODE_LO] != MODE_MAIN;
			if (out_valid && out_ready &&
				out_word[MODE_HI:MODE_LO] != MODE_MAIN)
				o_ctrl_word <= out_word;
		end
	end

	// Input registers take main value writes
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			for (int i = 0; i < CHAN_N; i++)
				input_r[i] <= CODE_RST;
		end
		else if (!clear_n_r)
		begin
			for (int i = 0; i < CHAN_N; i++)
				input_r[i] <= CODE_RST;
		end
		else if (out_valid && out_word[MODE_HI:MODE_LO] == MODE_MAIN)
			input_r[chan] <= out_word[CODE_W-1:0];
	end

	// all channels move together
	// Held low, each write reaches its output one cycle after decode.
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			for (int i = 0; i < CHAN_N; i++)
				out_code_r[i] <= CODE_RST;
		end
		else if (!clear_n_r)
		begin
			for (int i = 0; i < CHAN_N; i++)
				out_code_r[i] <= CODE_RST;
		end
		else if (!load_n_r)
		begin
			for (int i = 0; i < CHAN_N; i++)
				out_code_r[i] <= input_r[i];
		end
	end

	// Flatten; channel 0 in the low bits
	always_comb
	begin
		for (int i = 0; i < CHAN_N; i++)
			o_dac_code[i*CODE_W +: CODE_W] = out_code_r[i];
	end
endmodule : sdl_loader

/* sim/sdl_host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Host serial port, driven only by the bench
module sdl_host (
	output logic o_sclk,
	output logic o_sdo,
	output logic o_fs_n
);
	// Link clock stands low outside frames
	initial
	begin
		o_sclk = 0;
		o_sdo = 0;
		o_fs_n = 1;
	end
	// One frame of n bits; fs high only when a scenario asks
	task automatic send(input logic [15:0] w, input int n, input logic fs);
		o_fs_n = fs;
		#3;
		for (int i = 15; i > 15 - n; i--)
		begin
			// change on rising edge, top bit first
			o_sclk = 1;
			o_sdo = w[i];
			#3;
			o_sclk = 0;
			#3;
			// pause between bytes, sync kept low
			if (i == 8)
				#20;
		end
		o_sdo = ~o_sdo;
		o_fs_n = 1;
		#6;
	endtask : send
endmodule : sdl_host

/* sim/sdl_loader_monitor.sv */
`timescale 1ns/1ps

// ==========================================================
// Port checker of the loader
module sdl_loader_monitor
	import sdl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_load_outputs_n,
	input wire logic i_clear_outputs_n,
	input wire logic [CHAN_N*CODE_W-1:0] o_dac_code,
	input wire logic [WORD_W-1:0] o_ctrl_word,
	input wire logic o_ctrl_strobe,
	input wire logic o_link_ready,
	input wire logic o_word_dropped
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// Eight cycles cover the pin filter plus the output flop
	property p_hold;
		(i_load_outputs_n && i_clear_outputs_n)[*8] |-> $stable(o_dac_code);
	endproperty
	property p_clear;
		!i_clear_outputs_n[*8] |-> o_dac_code == '0;
	endproperty
	property p_stall;
		!i_clear_outputs_n[*8] |-> !o_ctrl_strobe;
	endproperty
	property p_ctrl_hold;
		!o_ctrl_strobe |-> $stable(o_ctrl_word);
	endproperty
	property p_ctrl_mode;
		o_ctrl_strobe |-> o_ctrl_word[MODE_HI:MODE_LO] != MODE_MAIN;
	endproperty
	property p_drop_keep;
		o_word_dropped |=> o_word_dropped;
	endproperty
	property p_drop_full;
		// Ready falls on or before the edge that the flag rises
		$rose(o_word_dropped) |-> !o_link_ready;
	endproperty
	property p_drain;
		i_clear_outputs_n[*8] |-> o_link_ready;
	endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	a_clear: assert property (p_clear) else $error("clear");
	a_stall: assert property (p_stall) else $error("stall");
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctl");
	a_ctrl_mode: assert property (p_ctrl_mode) else $error("mode");
	a_drop_keep: assert property (p_drop_keep) else $error("drop");
	a_drop_full: assert property (p_drop_full) else $error("full");
	a_drain: assert property (p_drain) else $error("drain");
	c_strobe: cover property (o_ctrl_strobe);
	c_drop: cover property ($rose(o_word_dropped));
	c_load: cover property ($changed(o_dac_code) && i_clear_outputs_n);
endmodule : sdl_loader_monitor

bind sdl_loader sdl_loader_monitor i_mon (.i_sys_clk, .i_reset_n,
	.i_load_outputs_n, .i_clear_outputs_n, .o_dac_code, .o_ctrl_word,
	.o_ctrl_strobe, .o_link_ready, .o_word_dropped);

/* sim/sdl_loader_bench.sv */
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench of the loader
module sdl_loader_bench
	import sdl_pkg::*;
;
	logic clk = 0, rst_n = 0, load_n = 1, clr_n = 1, sclk, sdo, fs_n;
	logic [CHAN_N*CODE_W-1:0] dac;
	logic [WORD_W-1:0] cw;
	logic cs, rdy, drop;
	int n_fail = 0;
	int tests_run = 0;
	// 40 MHz system clock
	always #12.5 clk = ~clk;
	sdl_host h (.o_sclk(sclk), .o_sdo(sdo), .o_fs_n(fs_n));
	sdl_loader i_dut (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_serial_clock_in(sclk), .i_serial_data_in(sdo),
		.i_frame_sync_n(fs_n), .i_load_outputs_n(load_n),
		.i_clear_outputs_n(clr_n), .o_dac_code(dac), .o_ctrl_word(cw),
		.o_ctrl_strobe(cs), .o_link_ready(rdy), .o_word_dropped(drop));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// Held-low load, then a short frame and a deselected frame
	task automatic t_auto;
		load_n = 0;
		h.send(16'h23ff, 16, 1'b0);
		cyc(12);
		chk("ch0", 16'h03ff, 16'(dac[9:0]));
		h.send(16'h2000, 10, 1'b0);
		h.send(16'h2000, 16, 1'b1);
		cyc(12);
		chk("ch0 kept", 16'h03ff, 16'(dac[9:0]));
	endtask : t_auto
	// Two channels loaded, then one load for both
	task automatic t_group;
		load_n = 1;
		cyc(8);
		h.send(16'h2455, 16, 1'b0);
		h.send(16'h2aaa, 16, 1'b0);
		cyc(12);
		chk("ch1 held", 16'h0000, 16'(dac[19:10]));
		load_n = 0;
		cyc(8);
		chk("ch1", 16'h0055, 16'(dac[19:10]));
		chk("ch2", 16'h02aa, 16'(dac[29:20]));
	endtask : t_group
	// One word, then a short load pulse; a later word waits for its own
	task automatic t_pulse;
		load_n = 1;
		cyc(8);
		h.send(16'h2c12, 16, 1'b0);
		cyc(12);
		chk("ch3 held", 16'h0000, 16'(dac[39:30]));
		load_n = 0;
		cyc(6);
		load_n = 1;
		cyc(8);
		chk("ch3", 16'h0012, 16'(dac[39:30]));
		h.send(16'h2c34, 16, 1'b0);
		cyc(12);
		chk("ch3 kept", 16'h0012, 16'(dac[39:30]));
	endtask : t_pulse
	// Control word waits for its strobe
	task automatic t_ctrl;
		int k;
		h.send(16'h0060, 16, 1'b0);
		for (k = 0; k < 20 && cs !== 1'b1; k++)
			cyc(1);
		if (k == 20)
		begin
			n_fail++;
			$display("wrong value ctrl strobe expected 1 seen 0");
			report_and_stop();
		end
		else
		begin
			chk("ctrl", 16'h0060, cw);
			cyc(1);
			// Strobe stands for one cycle only
			chk("strobe", 16'h0000, 16'(cs));
		end
	endtask : t_ctrl
	// Clear stalls the drain so the buffer fills and refuses
	task automatic t_fill;
		clr_n = 0;
		load_n = 0;
		cyc(8);
		chk("cleared", 16'h0000, dac[15:0]);
		for (int i = 0; i < FIFO_DEPTH + 2; i++)
			h.send(16'h3c00 + 16'(i), 16, 1'b0);
		cyc(8);
		chk("full", 16'h0001, {14'h0, rdy, drop});
		clr_n = 1;
		cyc(60);
		chk("drained", 16'h0003, {14'h0, rdy, drop});
		// Last kept word wins; the two refused ones never land
		chk("ch7", 16'h001f, 16'(dac[79:70]));
	endtask : t_fill
	// Main sequence
	initial
	begin
		cyc(12);
		rst_n = 1;
		cyc(4);
		t_auto();
		t_group();
		t_pulse();
		t_ctrl();
		t_fill();
		report_and_stop();
	end
endmodule : sdl_loader_bench
